// ===== rtl/efe_pkg.sv
// shared constants, types and the crc step for the frame encapsulation block
package efe_pkg;
   // ------------------------------------------------------------
   // line codes and crc
   // ------------------------------------------------------------
   localparam logic [7:0] EFE_PRE = 8'h55;
   localparam logic [7:0] EFE_SFD = 8'hD5;
   localparam logic [7:0] EFE_PAD = 8'h00;
   localparam logic [7:0] EFE_ONES8 = 8'hFF;
   localparam logic [31:0] EFE_CRC_POLY = 32'hEDB8_8320; // reflected generator
   localparam logic [31:0] EFE_CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] EFE_CRC_RESID = 32'hDEBB_20E3; // good-frame remainder
   localparam logic [2:0] EFE_PRE_LAST = 3'd6;
   localparam logic [1:0] EFE_FCS_LAST = 2'd3;
   // ------------------------------------------------------------
   // frame sizes and field positions, in octets from the destination
   // ------------------------------------------------------------
   localparam logic [15:0] EFE_TYPE_MIN = 16'h0600;
   localparam logic [15:0] EFE_LT_VLAN = 16'h8100;
   localparam logic [15:0] EFE_LT_PAUSE = 16'h8808;
   localparam logic [15:0] EFE_MIN_FRAME = 16'h0040;
   localparam logic [15:0] EFE_PAD_LAST = 16'h003B;
   localparam logic [15:0] EFE_MAX_FRAME = 16'h05EE;
   localparam logic [15:0] EFE_VLAN_EXTRA = 16'h0004;
   localparam logic [15:0] EFE_MIN_DATA = 16'h002E;
   localparam logic [15:0] EFE_HDR_LEN = 16'h000E;
   localparam logic [15:0] EFE_OVH_LEN = 16'h0012;
   localparam logic [15:0] EFE_FCS_LEN = 16'h0004;
   localparam logic [15:0] EFE_DA_LEN = 16'h0006;
   localparam logic [15:0] EFE_LT_HI = 16'h000C;
   localparam logic [15:0] EFE_LT_LO = 16'h000D;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] EFE_ADDR_CTRL = 8'h00;
   localparam logic [7:0] EFE_ADDR_STAT = 8'h04;
   localparam logic [7:0] EFE_ADDR_GOOD = 8'h08;
   localparam logic [7:0] EFE_ADDR_BAD = 8'h0C;
   localparam logic [5:0] EFE_CTRL_RST = 6'h23;
   typedef struct packed {
      logic vlan_en, jumbo_en, len_chk, rx_fcs_pass, tx_fcs_ins, tx_pad_en;
   } efe_cfg_s;
   typedef struct packed {
      logic bad, len_err, size_err, crc_err, pause, vlan, is_type, bcast, mcast;
   } efe_stat_s;
   typedef struct packed {
      logic dv;
      logic [7:0] d;
   } efe_rxpin_s;
   typedef enum logic [2:0] {
      T_IDLE = 3'b000, T_PRE = 3'b001, T_SFD = 3'b010,
      T_DATA = 3'b011, T_PAD = 3'b100, T_FCS = 3'b101
   } efe_tx_e;
   typedef enum logic [1:0] {R_IDLE = 2'b00, R_DATA = 2'b01, R_DROP = 2'b10} efe_rx_e;
   // one octet into the crc, least significant bit first
   function automatic logic [31:0] efe_crc8(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ EFE_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// ===== rtl/efe_frame.sv
// frame encapsulation and decapsulation with an ahb-lite register slave
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// How it works
// - seven 0x55 preamble octets before each frame
// - receive strips preamble; bare delimiter still accepted
// - delimiter 0xD5 sent and used to spot start
// - delivered receive data starts at destination address
// - first address bit marks group; broadcast all ones
// - octets go out least significant bit first
// - length/type 1536 or above means type
// - 8100 marks vlan, 8808 marks pause
// - vlan frames may be four octets longer
// - transmit passes length/type untouched
// - length frames lose pad unless fcs passed
// - optional length check flags mismatches
// - type frames pass untouched; field always kept
// - 0 to 1500 data, jumbo when enabled
// - auto pad to 64 octets, then fcs
// - user pad: config picks who adds fcs
// - crc-32 over addresses, type, data, pad
// - crc sent highest order term first
// - every received fcs checked, bad flagged
// - config bit forwards or strips received fcs
// - bad frame marked by tuser on last beat
module efe_frame
   import efe_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] tx_tdata,
   input wire logic tx_tvalid,
   input wire logic tx_tlast,
   output logic tx_tready,
   output logic [7:0] gmii_txd,
   output logic gmii_tx_en,
   input wire logic [7:0] gmii_rxd,
   input wire logic gmii_rx_dv,
   output logic [7:0] rx_tdata,
   output logic rx_tvalid,
   output logic rx_tlast,
   output logic rx_tuser
);
   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   efe_cfg_s cfg_reg;
   efe_stat_s stat_reg;
   logic [15:0] good_cnt_reg, bad_cnt_reg;
   logic pend_reg, wr_reg;
   logic [7:0] addr_reg;
   logic [31:0] rd_w;

   // read mux; unmapped offsets read zero
   always_comb begin
      case (addr_reg)
         EFE_ADDR_CTRL: rd_w = {26'h000_0000, cfg_reg};
         EFE_ADDR_STAT: rd_w = {23'h00_0000, stat_reg};
         EFE_ADDR_GOOD: rd_w = {16'h0000, good_cnt_reg};
         EFE_ADDR_BAD: rd_w = {16'h0000, bad_cnt_reg};
         default: rd_w = 32'h0000_0000;
      endcase
   end

   // one wait state: hwdata is only valid in the data phase
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_reg <= 1'b0;
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1]) begin
         pend_reg <= 1'b1;
         wr_reg <= hwrite;
         addr_reg <= haddr[7:0];
         hreadyout <= 1'b0;
      end else if (pend_reg) begin
         pend_reg <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= wr_reg ? 32'h0000_0000 : rd_w;
      end
   end

   // control register, hsize is ignored so writes of any size land
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_reg <= EFE_CTRL_RST;
      end else if (pend_reg && wr_reg && addr_reg == EFE_ADDR_CTRL) begin
         cfg_reg <= hwdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // transmit encapsulation
   // ------------------------------------------------------------
   efe_tx_e tx_st;
   logic [2:0] pre_i_reg;
   logic [1:0] fcs_i_reg;
   logic [15:0] tx_cnt_reg;
   logic [31:0] tx_crc_reg;
   logic tx_take_w;
   assign tx_take_w = tx_tvalid && tx_tready;

   // octets leave whole; the phy shifts them out lsb first
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_st <= T_IDLE;
         pre_i_reg <= 3'd0;
         fcs_i_reg <= 2'd0;
         tx_cnt_reg <= 16'h0000;
         tx_crc_reg <= EFE_CRC_INIT;
         tx_tready <= 1'b0;
         gmii_txd <= 8'h00;
         gmii_tx_en <= 1'b0;
      end else begin
         case (tx_st)
            T_IDLE: begin
               // tx_en drops for at least one cycle between frames
               gmii_tx_en <= 1'b0;
               if (tx_tvalid && !gmii_tx_en) begin
                  gmii_tx_en <= 1'b1;
                  gmii_txd <= EFE_PRE;
                  pre_i_reg <= 3'd1;
                  tx_st <= T_PRE;
               end
            end
            T_PRE: begin
               gmii_txd <= EFE_PRE;
               pre_i_reg <= pre_i_reg + 3'd1;
               if (pre_i_reg == EFE_PRE_LAST) begin
                  tx_st <= T_SFD;
               end
            end
            T_SFD: begin
               gmii_txd <= EFE_SFD;
               tx_crc_reg <= EFE_CRC_INIT;
               tx_cnt_reg <= 16'h0000;
               tx_tready <= 1'b1;
               tx_st <= T_DATA;
            end
            T_DATA: begin
               if (tx_take_w) begin
                  // addresses and length/type go out as given
                  gmii_txd <= tx_tdata;
                  tx_crc_reg <= efe_crc8(tx_crc_reg, tx_tdata);
                  tx_cnt_reg <= tx_cnt_reg + 16'h0001;
                  fcs_i_reg <= 2'd0;
                  if (tx_tlast) begin
                     tx_tready <= 1'b0;
                     if (cfg_reg.tx_pad_en && tx_cnt_reg < EFE_PAD_LAST) begin
                        tx_st <= T_PAD;
                     end else if (cfg_reg.tx_pad_en || cfg_reg.tx_fcs_ins) begin
                        tx_st <= T_FCS;
                     end else begin
                        tx_st <= T_IDLE;
                     end
                  end
               end else begin
                  // underrun: the line cannot stall, so the frame is cut short
                  gmii_tx_en <= 1'b0;
                  tx_tready <= 1'b0;
                  tx_st <= T_IDLE;
               end
            end
            T_PAD: begin
               gmii_txd <= EFE_PAD;
               tx_crc_reg <= efe_crc8(tx_crc_reg, EFE_PAD);
               tx_cnt_reg <= tx_cnt_reg + 16'h0001;
               if (tx_cnt_reg == EFE_PAD_LAST) begin
                  tx_st <= T_FCS;
               end
            end
            T_FCS: begin
               // low register octet carries x31 in its lsb
               gmii_txd <= ~tx_crc_reg[{fcs_i_reg, 3'b000} +: 8];
               fcs_i_reg <= fcs_i_reg + 2'd1;
               if (fcs_i_reg == EFE_FCS_LAST) begin
                  tx_st <= T_IDLE;
               end
            end
            default: tx_st <= T_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // receive pin synchroniser
   // ------------------------------------------------------------
   efe_rxpin_s rx_s1_reg, rx_s2_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_s1_reg <= '0;
         rx_s2_reg <= '0;
      end else begin
         rx_s1_reg <= {gmii_rx_dv, gmii_rxd};
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // receive decapsulation
   // ------------------------------------------------------------
   efe_rx_e rx_st;
   logic [15:0] rx_cnt_reg, lt_reg;
   logic [31:0] rx_crc_reg, dly_reg;
   logic mcast_reg, bcast_reg;
   logic rx_in_w, rx_end_w, cand_w, pad_mode_w;
   logic crc_err_w, size_err_w, len_err_w, bad_w, is_len_w, vlan_w;
   logic [15:0] idx_out_w, max_w;
   logic [7:0] cand_d_w;

   assign rx_in_w = rx_st == R_DATA && rx_s2_reg.dv;
   assign rx_end_w = rx_st == R_DATA && !rx_s2_reg.dv;
   assign is_len_w = lt_reg < EFE_TYPE_MIN;
   assign vlan_w = lt_reg == EFE_LT_VLAN;
   assign idx_out_w = rx_cnt_reg - EFE_FCS_LEN;
   // pad exists only for short length frames; type frames are never cut
   assign pad_mode_w = is_len_w && lt_reg < EFE_MIN_DATA;
   // four-octet delay hides the fcs unless it is passed on
   assign cand_w = rx_in_w && (cfg_reg.rx_fcs_pass || (rx_cnt_reg >= EFE_FCS_LEN &&
                   !(pad_mode_w && idx_out_w >= EFE_HDR_LEN + lt_reg)));
   assign cand_d_w = cfg_reg.rx_fcs_pass ? rx_s2_reg.d : dly_reg[31:24];
   // frame checks, all judged when dv falls
   assign crc_err_w = rx_crc_reg != EFE_CRC_RESID;
   assign max_w = EFE_MAX_FRAME + ((vlan_w && cfg_reg.vlan_en) ? EFE_VLAN_EXTRA : 16'h0000);
   assign size_err_w = rx_cnt_reg < EFE_MIN_FRAME ||
                       (!cfg_reg.jumbo_en && rx_cnt_reg > max_w);
   assign len_err_w = cfg_reg.len_chk && is_len_w && (pad_mode_w ?
                      rx_cnt_reg != EFE_MIN_FRAME :
                      rx_cnt_reg != lt_reg + EFE_OVH_LEN);
   assign bad_w = crc_err_w || size_err_w || len_err_w;

   // hunt for the delimiter, then count and check the frame
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_st <= R_IDLE;
         rx_cnt_reg <= 16'h0000;
         rx_crc_reg <= EFE_CRC_INIT;
         dly_reg <= 32'h0000_0000;
         lt_reg <= 16'h0000;
         mcast_reg <= 1'b0;
         bcast_reg <= 1'b0;
      end else begin
         case (rx_st)
            R_IDLE: begin
               if (rx_s2_reg.dv) begin
                  if (rx_s2_reg.d == EFE_SFD) begin
                     // preamble octets are skipped, and may be absent
                     rx_st <= R_DATA;
                     rx_cnt_reg <= 16'h0000;
                     rx_crc_reg <= EFE_CRC_INIT;
                     lt_reg <= 16'h0000;
                     bcast_reg <= 1'b1;
                  end else if (rx_s2_reg.d != EFE_PRE) begin
                     rx_st <= R_DROP;
                  end
               end
            end
            R_DATA: begin
               if (rx_s2_reg.dv) begin
                  rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                  rx_crc_reg <= efe_crc8(rx_crc_reg, rx_s2_reg.d);
                  dly_reg <= {dly_reg[23:0], rx_s2_reg.d};
                  if (rx_cnt_reg == 16'h0000) begin
                     mcast_reg <= rx_s2_reg.d[0];
                  end
                  if (rx_cnt_reg < EFE_DA_LEN && rx_s2_reg.d != EFE_ONES8) begin
                     bcast_reg <= 1'b0;
                  end
                  if (rx_cnt_reg == EFE_LT_HI) begin
                     lt_reg[15:8] <= rx_s2_reg.d;
                  end
                  if (rx_cnt_reg == EFE_LT_LO) begin
                     lt_reg[7:0] <= rx_s2_reg.d;
                  end
               end else begin
                  rx_st <= R_IDLE;
               end
            end
            R_DROP: begin
               if (!rx_s2_reg.dv) begin
                  rx_st <= R_IDLE;
               end
            end
            default: rx_st <= R_IDLE;
         endcase
      end
   end

   // one octet is held back so tlast can ride on the real last octet
   logic [7:0] hold_reg;
   logic hold_v_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_reg <= 8'h00;
         hold_v_reg <= 1'b0;
         rx_tdata <= 8'h00;
         rx_tvalid <= 1'b0;
         rx_tlast <= 1'b0;
         rx_tuser <= 1'b0;
      end else begin
         rx_tvalid <= 1'b0;
         rx_tlast <= 1'b0;
         rx_tuser <= 1'b0;
         if (cand_w) begin
            if (hold_v_reg) begin
               rx_tvalid <= 1'b1;
               rx_tdata <= hold_reg;
            end
            hold_reg <= cand_d_w;
            hold_v_reg <= 1'b1;
         end else if (rx_end_w) begin
            // a frame with nothing to deliver still gets a lone error beat
            rx_tvalid <= 1'b1;
            rx_tlast <= 1'b1;
            rx_tuser <= bad_w;
            rx_tdata <= hold_v_reg ? hold_reg : 8'h00;
            hold_v_reg <= 1'b0;
         end
      end
   end

   // last-frame status and wrapping frame counters
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stat_reg <= '0;
         good_cnt_reg <= 16'h0000;
         bad_cnt_reg <= 16'h0000;
      end else if (rx_end_w) begin
         stat_reg <= {bad_w, len_err_w, size_err_w, crc_err_w, lt_reg == EFE_LT_PAUSE,
                      vlan_w, !is_len_w, bcast_reg, mcast_reg};
         if (bad_w) begin
            bad_cnt_reg <= bad_cnt_reg + 16'h0001;
         end else begin
            good_cnt_reg <= good_cnt_reg + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_preamble;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(gmii_tx_en) |-> (gmii_txd == EFE_PRE) [*7] ##1 (gmii_txd == EFE_SFD);
   endproperty
   a_preamble: assert property (p_preamble) else $error("bad preamble or delimiter");

   property p_crc_preset;
      @(posedge sys_clk) disable iff (!reset_n)
      (tx_st == T_SFD) |=> (tx_crc_reg == EFE_CRC_INIT) && gmii_txd == EFE_SFD;
   endproperty
   a_crc_preset: assert property (p_crc_preset) else $error("crc not preset");

   property p_pass_through;
      @(posedge sys_clk) disable iff (!reset_n)
      tx_take_w |=> gmii_tx_en && gmii_txd == $past(tx_tdata);
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("tx data altered");

   property p_min_len;
      @(posedge sys_clk) disable iff (!reset_n)
      (tx_st == T_FCS && fcs_i_reg == 2'd0 && cfg_reg.tx_pad_en) |-> tx_cnt_reg > EFE_PAD_LAST;
   endproperty
   a_min_len: assert property (p_min_len) else $error("frame not padded");

   property p_no_out_idle;
      @(posedge sys_clk) disable iff (!reset_n)
      (rx_st == R_IDLE && $past(rx_st) == R_IDLE) |-> !rx_tvalid;
   endproperty
   a_no_out_idle: assert property (p_no_out_idle) else $error("data outside frame");

   property p_user_last;
      @(posedge sys_clk) disable iff (!reset_n)
      rx_tuser |-> rx_tlast && rx_tvalid;
   endproperty
   a_user_last: assert property (p_user_last) else $error("tuser without tlast");

   property p_crc_bad;
      @(posedge sys_clk) disable iff (!reset_n)
      (rx_end_w && crc_err_w) |=> rx_tuser ##1 stat_reg.crc_err;
   endproperty
   a_crc_bad: assert property (p_crc_bad) else $error("fcs error not flagged");

   property p_len_bad;
      @(posedge sys_clk) disable iff (!reset_n)
      (rx_end_w && len_err_w) |=> rx_tuser && rx_tlast;
   endproperty
   a_len_bad: assert property (p_len_bad) else $error("length error not flagged");

   property p_vlan_flag;
      @(posedge sys_clk) disable iff (!reset_n)
      (rx_end_w && lt_reg == EFE_LT_VLAN) |=> stat_reg.vlan && stat_reg.is_type;
   endproperty
   a_vlan_flag: assert property (p_vlan_flag) else $error("vlan not seen");
endmodule // efe_frame

// ===== tb/efe_phy_model.sv
// line-side phy model: replays receive octets and records transmit octets
`timescale 1ns/1ps
module efe_phy_model (
   input wire logic sys_clk,
   input wire logic [7:0] gmii_txd,
   input wire logic gmii_tx_en,
   output logic [7:0] gmii_rxd,
   output logic gmii_rx_dv
);
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   // --------
   // line drive
   // --------
   initial begin
      gmii_rxd = 8'h00;
      gmii_rx_dv = 1'b0;
   end
   // idle data toggles so a stale octet never passes for a live one
   always @(posedge sys_clk) begin
      if (rxq.size() > 0) begin
         gmii_rx_dv <= 1'b1;
         gmii_rxd <= rxq.pop_front();
      end else begin
         gmii_rx_dv <= 1'b0;
         gmii_rxd <= ~gmii_rxd;
      end
   end
   // record every octet while transmit enable is up
   always @(posedge sys_clk) begin
      if (gmii_tx_en === 1'b1) begin
         txq.push_back(gmii_txd);
      end
   end
   // queue one frame: optional preamble, delimiter, then the octets
   task automatic load(input logic [7:0] f[$], input bit pre);
      if (pre) begin
         repeat (7) rxq.push_back(8'h55);
      end
      rxq.push_back(8'hD5);
      foreach (f[i]) rxq.push_back(f[i]);
   endtask
endmodule // efe_phy_model

// ===== tb/efe_frame_tb.sv
// self-checking bench for the frame encapsulation block
`timescale 1ns/1ps
module efe_frame_tb
   import efe_pkg::*;
;
   typedef logic [7:0] efe_bq_t[$];
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [7:0] tx_tdata = 8'h00;
   logic tx_tvalid = 1'b0;
   logic tx_tlast = 1'b0;
   logic hready, hreadyout, hresp, tx_tready, gmii_tx_en, gmii_rx_dv;
   logic [31:0] hrdata;
   logic [7:0] gmii_txd, gmii_rxd, rx_tdata;
   logic rx_tvalid, rx_tlast, rx_tuser;
   // only the capture process writes this; scenarios read it
   int rx_frames = 0;
   logic rx_bad = 1'b0;
   int fails = 0;
   int checks = 0;
   efe_bq_t rxq;
   // single slave, so its ready is the bus ready
   assign hready = hreadyout;
   always #50 sys_clk = ~sys_clk;
   efe_frame dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_tdata(tx_tdata),
      .tx_tvalid(tx_tvalid), .tx_tlast(tx_tlast), .tx_tready(tx_tready),
      .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .gmii_rxd(gmii_rxd),
      .gmii_rx_dv(gmii_rx_dv), .rx_tdata(rx_tdata), .rx_tvalid(rx_tvalid),
      .rx_tlast(rx_tlast), .rx_tuser(rx_tuser));
   efe_phy_model phy_u (.sys_clk(sys_clk), .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en),
      .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv));
   // --------
   // receive capture and helpers
   // --------
   // no tready on receive, so every beat is taken as it comes
   always @(posedge sys_clk) begin
      if (rx_tvalid === 1'b1) begin
         rxq.push_back(rx_tdata);
         if (rx_tlast === 1'b1) begin
            rx_bad = rx_tuser;
            rx_frames++;
         end
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (e !== g) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one single-word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (hready !== 1'b1 && n < 50);
      r = hrdata;
      chk("hresp", 32'h0000_0000, {31'd0, hresp});
   endtask
   // frame from destination to pad; each destination address octet repeats da0
   function automatic efe_bq_t mk(input logic [7:0] da0, input logic [15:0] lt,
      input int nd, input int np);
      efe_bq_t q;
      repeat (6) q.push_back(da0);
      for (int i = 0; i < 6; i++) q.push_back(8'h10 + i[7:0]);
      q.push_back(lt[15:8]);
      q.push_back(lt[7:0]);
      for (int i = 0; i < nd; i++) q.push_back(8'hA0 ^ i[7:0]);
      repeat (np) q.push_back(EFE_PAD);
      return q;
   endfunction
   // reference crc: preset ones, lsb first, complement sent low octet first
   function automatic efe_bq_t add_fcs(input efe_bq_t q, input bit bad);
      logic [31:0] c;
      c = 32'hFFFF_FFFF;
      foreach (q[i]) for (int b = 0; b < 8; b++) c = (c[0] ^ q[i][b]) ?
         ((c >> 1) ^ EFE_CRC_POLY) : (c >> 1);
      c = ~c ^ {31'd0, bad};
      for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]);
      return q;
   endfunction
   task automatic rx_run(input efe_bq_t f, input bit pre, input efe_bq_t e, input logic bad);
      int n;
      int f0;
      rxq.delete();
      f0 = rx_frames;
      phy_u.load(f, pre);
      n = 0;
      while (rx_frames == f0 && n < 3000) begin @(posedge sys_clk); n++; end
      chk("rx_len", e.size(), rxq.size());
      foreach (e[i]) chk("rx_data", e[i], rxq[i]);
      chk("rx_tuser", {31'd0, bad}, {31'd0, rx_bad});
   endtask
   task automatic tx_run(input efe_bq_t u, input efe_bq_t e);
      int n;
      phy_u.txq.delete();
      @(posedge sys_clk);
      foreach (u[i]) begin
         tx_tdata <= u[i];
         tx_tlast <= (i == u.size() - 1);
         tx_tvalid <= 1'b1;
         n = 0;
         do begin @(posedge sys_clk); n++; end while (tx_tready !== 1'b1 && n < 100);
      end
      tx_tvalid <= 1'b0;
      tx_tlast <= 1'b0;
      n = 0;
      while (gmii_tx_en !== 1'b0 && n < 300) begin @(posedge sys_clk); n++; end
      @(posedge sys_clk);
      chk("tx_len", e.size() + 8, phy_u.txq.size());
      for (int i = 0; i < 7; i++) chk("tx_pre", EFE_PRE, phy_u.txq[i]);
      chk("tx_sfd", EFE_SFD, phy_u.txq[7]);
      foreach (e[i]) chk("tx_data", e[i], phy_u.txq[i+8]);
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_regs;
      logic [31:0] r;
      ahb(1'b0, EFE_ADDR_CTRL, 32'h0, r);
      chk("ctrl_rst", {26'd0, EFE_CTRL_RST}, r);
      ahb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
      ahb(1'b0, 8'h10, 32'h0, r);
      chk("unmapped", 32'h0000_0000, r);
      ahb(1'b0, EFE_ADDR_CTRL, 32'h0, r);
      chk("ctrl_kept", {26'd0, EFE_CTRL_RST}, r);
   endtask
   // type frames of each class, one without preamble
   task automatic t_rx_types;
      logic [15:0] lt[3] = '{16'h0800, EFE_LT_VLAN, EFE_LT_PAUSE};
      logic [7:0] da[3] = '{8'hFF, 8'h01, 8'h02};
      logic [31:0] s;
      for (int k = 0; k < 3; k++) begin
         rx_run(add_fcs(mk(da[k], lt[k], 46, 0), 0), k != 1, mk(da[k], lt[k], 46, 0), 0);
         ahb(1'b0, EFE_ADDR_STAT, 32'h0, s);
         chk("stat_type", {29'd0, k == 2, k == 1, 1'b1}, {29'd0, s[4:2]});
         chk("stat_bcast", {31'd0, k == 0}, {31'd0, s[1]});
         if (k != 0) chk("stat_mcast", {31'd0, k == 1}, {31'd0, s[0]});
      end
      ahb(1'b0, EFE_ADDR_GOOD, 32'h0, s);
      chk("good_cnt", 32'h0000_0003, s);
   endtask
   // pad dropped on a true length; wrong length flagged when checking
   task automatic t_rx_len;
      logic [31:0] s;
      ahb(1'b1, EFE_ADDR_CTRL, 32'h0000_002B, s);
      rx_run(add_fcs(mk(8'h02, 16'h0002, 2, 44), 0), 1, mk(8'h02, 16'h0002, 2, 0), 0);
      rx_run(add_fcs(mk(8'h02, 16'h0030, 46, 0), 0), 1, mk(8'h02, 16'h0030, 46, 0), 1);
      ahb(1'b0, EFE_ADDR_STAT, 32'h0, s);
      chk("stat_len", 32'h0000_0001, {31'd0, s[7]});
   endtask
   task automatic t_rx_crc;
      logic [31:0] s;
      rx_run(add_fcs(mk(8'hFF, 16'h0800, 46, 0), 1), 1, mk(8'hFF, 16'h0800, 46, 0), 1);
      ahb(1'b0, EFE_ADDR_STAT, 32'h0, s);
      chk("stat_crc", 32'h0000_0003, {30'd0, s[8], s[5]});
      ahb(1'b0, EFE_ADDR_BAD, 32'h0, s);
      chk("bad_cnt", 32'h0000_0002, s);
   endtask
   // check-sequence passing hands over pad and fcs as well
   task automatic t_rx_pass;
      logic [31:0] s;
      ahb(1'b1, EFE_ADDR_CTRL, 32'h0000_0027, s);
      rx_run(add_fcs(mk(8'h02, 16'h0002, 2, 44), 0), 1,
         add_fcs(mk(8'h02, 16'h0002, 2, 44), 0), 0);
   endtask
   // auto pad, device fcs on user pad, user fcs
   task automatic t_tx;
      logic [31:0] s;
      ahb(1'b1, EFE_ADDR_CTRL, 32'h0000_0023, s);
      tx_run(mk(8'h02, 16'h0002, 2, 0), add_fcs(mk(8'h02, 16'h0002, 2, 44), 0));
      ahb(1'b1, EFE_ADDR_CTRL, 32'h0000_0022, s);
      tx_run(mk(8'h01, 16'h8808, 46, 0), add_fcs(mk(8'h01, 16'h8808, 46, 0), 0));
      ahb(1'b1, EFE_ADDR_CTRL, 32'h0000_0020, s);
      tx_run(add_fcs(mk(8'hFF, 16'h0005, 46, 0), 0), add_fcs(mk(8'hFF, 16'h0005, 46, 0), 0));
   endtask
   // --------
   // main sequence and watchdog
   // --------
   initial begin
      repeat (5) @(posedge sys_clk);
      chk("rst_ready", 32'h0000_0001, {31'd0, hreadyout});
      chk("rst_tx_en", 32'h0000_0000, {31'd0, gmii_tx_en});
      reset_n <= 1'b1;
      t_regs();
      t_rx_types();
      t_rx_len();
      t_rx_crc();
      t_rx_pass();
      t_tx();
      final_report();
   end
   // the whole run needs well under 5000 cycles
   initial begin
      #2_000_000;
      fails++;
      final_report();
   end
endmodule // efe_frame_tb
